// file: rtl/core_mem_defines.vh
// Offsets, field positions, reset values and sizes for the core memory map block.
`ifndef CORE_MEM_DEFINES_VH
`define CORE_MEM_DEFINES_VH
`define SFR_MATH     8'hE0
`define SFR_OPND_B   8'hF0
`define SFR_STACK    8'h81
`define SFR_PTR_LOW  8'h82
`define SFR_PTR_HIGH 8'h83
`define SFR_PTR_PAGE 8'h84
`define SFR_POWER    8'h87
`define SFR_STATUS   8'hD0
`define STACK_RESET  8'h07
`define STATUS_RESET 8'h00
`define POWER_RESET  8'h00
`define ST_CARRY     7
`define ST_HALF      6
`define ST_USER_A    5
`define ST_BANK_HI   4
`define ST_BANK_LO   3
`define ST_WRAP      2
`define ST_USER_B    1
`define ST_PARITY    0
`define PW_STROBE_OFF 4
`define PW_DOWN      1
`define PW_SLEEP     0
`define BIT_AREA_BASE 8'h20
`define FLASH_BYTES  640
`define CODE_BYTES   8192
`endif

// file: rtl/core_memory_map.v
// Internal data memory, core special-function registers and address resolution.
`timescale 1ns/100ps
`include "core_mem_defines.vh"

// Functional notes
// - External-access-select low at reset fetches code externally, else internal 8 Kbyte flash.
// - Internal data: lower RAM, upper RAM, special area, 640-byte data flash.
// - Lower RAM direct or indirect; upper RAM indirect only; special area direct only.
// - Data flash not mapped directly; reached through special-area control registers.
// - External data space reaches 16 MBytes using a 24-bit address.
// - Lowest 32 RAM bytes form four banks of eight working registers.
// - RAM bytes 20h to 2Fh are also bits 00h to 7Fh.
// - Stack may sit anywhere in internal RAM, up to 256 bytes deep.
// - Stack pointer resets to 07h and increments before each store.
// - Pointer has page, high, low bytes; 16-bit increment carries into page.
// - Status bits 4 and 3 select working register bank 0 to 3.
// - Status word layout fixed, bit-addressable, resets to 00h.
// - Power control resets to 00h, not bit-addressable, fixed bit layout.
// - Unoccupied special addresses hold nothing; writes ignored, reads unspecified.
// - Special registers at addresses ending 0h or 8h are bit-addressable.
// - Second operand register serves multiply and divide, else scratch.
// - Power control bit 4 suppresses the address-latch strobe.
module core_memory_map (
  input  wire        clock,            // Core clock, 250 MHz.
  input  wire        reset_n,          // Asynchronous reset, active low.
  input  wire        ext_access_sel,   // Boot source strap, low selects external code.
  input  wire        dir_we,           // Direct-address write strobe.
  input  wire        dir_re,           // Direct-address read strobe.
  input  wire [7:0]  dir_addr,         // Direct address.
  input  wire [7:0]  dir_wdata,        // Direct write data.
  input  wire        ind_we,           // Indirect write strobe.
  input  wire        ind_re,           // Indirect read strobe.
  input  wire [7:0]  ind_addr,         // Indirect address.
  input  wire [7:0]  ind_wdata,        // Indirect write data.
  input  wire        bit_we,           // Bit write strobe.
  input  wire        bit_re,           // Bit read strobe.
  input  wire [7:0]  bit_addr,         // Bit address.
  input  wire        bit_wdata,        // Bit write value.
  input  wire        reg_we,           // Working register write strobe.
  input  wire        reg_re,           // Working register read strobe.
  input  wire [2:0]  reg_sel,          // Working register number.
  input  wire [7:0]  reg_wdata,        // Working register write data.
  input  wire        push_req,         // Push one byte onto the stack.
  input  wire        pop_req,          // Pop one byte from the stack.
  input  wire [7:0]  push_data,        // Byte to push.
  input  wire        ptr_inc,          // Increment the data pointer.
  input  wire        flags_we,         // Arithmetic flag update strobe.
  input  wire [3:0]  flags_in,         // Carry, half carry, signed wrap, unused.
  input  wire        muldiv_we,        // Multiply or divide result write.
  input  wire [15:0] muldiv_res,       // Result: upper byte to operand b, lower to accumulator.
  output reg  [7:0]  rd_data,          // Read data, one cycle after a read strobe.
  output reg         rd_bit,           // Bit read value.
  output reg         rd_valid,         // Read data valid pulse.
  output reg         code_external,    // Code fetched from external program space.
  output reg  [23:0] ext_data_addr,    // 24-bit external data address from the pointer.
  output reg  [7:0]  bank_base,        // RAM address of the active working bank.
  output reg  [7:0]  stack_ptr_out,    // Current stack pointer.
  output reg  [7:0]  math_out,         // Accumulator value.
  output reg  [7:0]  opnd_b_out,       // Second operand register value.
  output reg         latch_strobe_en,  // Address-latch strobe allowed.
  output reg         power_down_req,   // Power-down requested.
  output reg         sleep_core_req,   // Idle requested.
  output reg         baud_doubler      // Baud rate doubling.
);

  reg  [7:0]  ram [0:255];
  reg  [7:0]  math_register;
  reg  [7:0]  opnd_b;
  reg  [7:0]  stack_ptr;
  reg  [7:0]  ptr_page_byte;
  reg  [7:0]  ptr_high_byte;
  reg  [7:0]  ptr_low_byte;
  reg  [7:0]  status_word;
  reg  [7:0]  power_ctl_reg;
  reg         strap_done;
  integer     i;
  reg  [7:0]  next_math;

  // Even parity over one byte: one when the count of ones is odd.
  function parity8;
    input [7:0] v;
    begin
      parity8 = ^v;
    end
  endfunction

  // Working register n of bank b sits at RAM address b*8+n.
  function [7:0] bank_slot;
    input [1:0] bank;
    input [2:0] n;
    begin
      bank_slot = {3'b000, bank, n};
    end
  endfunction

  wire [15:0] data_pointer_16 = {ptr_high_byte, ptr_low_byte};
  wire [16:0] ptr_sum         = {1'b0, data_pointer_16} + 17'h0_0001;
  wire [7:0]  stack_next      = stack_ptr + 8'h01;
  wire [7:0]  work_addr       = bank_slot(status_word[`ST_BANK_HI:`ST_BANK_LO],
                                          reg_sel);

  // Bit address 00h-7Fh maps into RAM 20h-2Fh; above, into special registers at x0h or x8h.
  function [7:0] bit_byte;
    input [7:0] ba;
    begin
      if (!ba[7])
        bit_byte = `BIT_AREA_BASE + {4'h0, ba[6:3]};
      else
        bit_byte = {ba[7:3], 3'b000};
    end
  endfunction

  // Only the registers this block owns exist; others read as zero and ignore writes.
  function is_sfr;
    input [7:0] a;
    begin
      case (a)
        `SFR_MATH, `SFR_OPND_B, `SFR_STACK, `SFR_PTR_LOW, `SFR_PTR_HIGH,
        `SFR_PTR_PAGE, `SFR_POWER, `SFR_STATUS: is_sfr = 1'b1;
        default: is_sfr = 1'b0;
      endcase
    end
  endfunction

  function [7:0] sfr_value;
    input [7:0] a;
    input [7:0] acc;
    input [7:0] b;
    input [7:0] sp;
    input [7:0] dl;
    input [7:0] dh;
    input [7:0] dp;
    input [7:0] pw;
    input [7:0] st;
    begin
      case (a)
        `SFR_MATH:     sfr_value = acc;
        `SFR_OPND_B:   sfr_value = b;
        `SFR_STACK:    sfr_value = sp;
        `SFR_PTR_LOW:  sfr_value = dl;
        `SFR_PTR_HIGH: sfr_value = dh;
        `SFR_PTR_PAGE: sfr_value = dp;
        `SFR_POWER:    sfr_value = pw;
        `SFR_STATUS:   sfr_value = {st[7:1], parity8(acc)};
        default:       sfr_value = 8'h00;
      endcase
    end
  endfunction

  // Direct addresses below 80h hit lower RAM, above hit the special area.
  wire        dir_sfr   = dir_addr[7];
  wire [7:0]  bbyte     = bit_byte(bit_addr);
  wire        bit_sfr   = bit_addr[7];
  wire [7:0]  bit_old   = bit_sfr ? sfr_value(bbyte, math_register, opnd_b, stack_ptr,
                          ptr_low_byte, ptr_high_byte, ptr_page_byte, power_ctl_reg,
                          status_word) : ram[bbyte];
  // The power register sits at 87h, so no bit address ever reaches it.
  wire        bit_ok    = !bit_sfr || bbyte == `SFR_STATUS || bbyte == `SFR_MATH ||
                          bbyte == `SFR_OPND_B;
  reg  [7:0]  bit_new;
  reg         sfr_we;
  reg  [7:0]  sfr_addr;
  reg  [7:0]  sfr_data;

  always @* begin
    bit_new              = bit_old;
    bit_new[bit_addr[2:0]] = bit_wdata;
    sfr_we   = 1'b0;
    sfr_addr = dir_addr;
    sfr_data = dir_wdata;
    if (dir_we && dir_sfr) begin
      sfr_we = 1'b1;
    end else if (bit_we && bit_sfr && bit_ok) begin
      sfr_we   = 1'b1;
      sfr_addr = bbyte;
      sfr_data = bit_new;
    end
  end

  // The stored parity bit follows the accumulator value that this edge will load.
  always @* begin
    next_math = math_register;
    if (sfr_we && sfr_addr == `SFR_MATH)
      next_math = sfr_data;
    if (muldiv_we)
      next_math = muldiv_res[7:0];
  end

  // Core registers; hardware updates come after software writes so they win.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      math_register <= 8'h00;
      opnd_b        <= 8'h00;
      stack_ptr     <= `STACK_RESET;
      ptr_low_byte  <= 8'h00;
      ptr_high_byte <= 8'h00;
      ptr_page_byte <= 8'h00;
      status_word   <= `STATUS_RESET;
      power_ctl_reg <= `POWER_RESET;
    end else begin
      if (sfr_we && is_sfr(sfr_addr)) begin
        case (sfr_addr)
          `SFR_MATH:     math_register <= sfr_data;
          `SFR_OPND_B:   opnd_b        <= sfr_data;
          `SFR_STACK:    stack_ptr     <= sfr_data;
          `SFR_PTR_LOW:  ptr_low_byte  <= sfr_data;
          `SFR_PTR_HIGH: ptr_high_byte <= sfr_data;
          `SFR_PTR_PAGE: ptr_page_byte <= sfr_data;
          `SFR_POWER:    power_ctl_reg <= sfr_data;
          `SFR_STATUS:   status_word[7:1] <= sfr_data[7:1];
          default:       math_register <= math_register;
        endcase
      end
      if (muldiv_we) begin
        math_register <= muldiv_res[7:0];
        opnd_b        <= muldiv_res[15:8];
      end
      if (flags_we) begin
        status_word[`ST_CARRY] <= flags_in[3];
        status_word[`ST_HALF]  <= flags_in[2];
        status_word[`ST_WRAP]  <= flags_in[1];
      end
      if (push_req)
        stack_ptr <= stack_next;
      else if (pop_req)
        stack_ptr <= stack_ptr - 8'h01;
      if (ptr_inc) begin
        ptr_low_byte  <= ptr_sum[7:0];
        ptr_high_byte <= ptr_sum[15:8];
        ptr_page_byte <= ptr_page_byte + {7'h00, ptr_sum[16]};
      end
      status_word[`ST_PARITY] <= parity8(next_math);
    end
  end

  // Internal RAM; the upper half is reached only through indirect or stack access.
  // Clearing every byte at reset costs area but keeps early reads defined.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < 256; i = i + 1)
        ram[i] <= 8'h00;
    end else begin
      if (dir_we && !dir_sfr)
        ram[dir_addr] <= dir_wdata;
      if (ind_we)
        ram[ind_addr] <= ind_wdata;
      if (bit_we && !bit_sfr)
        ram[bbyte] <= bit_new;
      if (reg_we)
        ram[work_addr] <= reg_wdata;
      if (push_req)
        ram[stack_next] <= push_data;
    end
  end

  // Read port and derived outputs, all registered.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data         <= 8'h00;
      rd_bit          <= 1'b0;
      rd_valid        <= 1'b0;
      code_external   <= 1'b0;
      strap_done      <= 1'b0;
      ext_data_addr   <= 24'h00_0000;
      bank_base       <= 8'h00;
      stack_ptr_out   <= `STACK_RESET;
      math_out        <= 8'h00;
      opnd_b_out      <= 8'h00;
      latch_strobe_en <= 1'b1;
      power_down_req  <= 1'b0;
      sleep_core_req  <= 1'b0;
      baud_doubler    <= 1'b0;
    end else begin
      rd_valid <= dir_re | ind_re | bit_re | reg_re | pop_req;
      if (dir_re)
        rd_data <= dir_sfr ? sfr_value(dir_addr, math_register, opnd_b, stack_ptr,
                   ptr_low_byte, ptr_high_byte, ptr_page_byte, power_ctl_reg,
                   status_word) : ram[dir_addr];
      else if (ind_re)
        rd_data <= ram[ind_addr];
      else if (reg_re)
        rd_data <= ram[work_addr];
      else if (pop_req)
        rd_data <= ram[stack_ptr];
      if (bit_re)
        rd_bit <= bit_ok ? bit_old[bit_addr[2:0]] : 1'b0;
      if (!strap_done) begin
        strap_done    <= 1'b1;
        code_external <= !ext_access_sel;
      end
      ext_data_addr   <= {ptr_page_byte, data_pointer_16};
      bank_base       <= bank_slot(status_word[`ST_BANK_HI:`ST_BANK_LO], 3'b000);
      stack_ptr_out   <= stack_ptr;
      math_out        <= math_register;
      opnd_b_out      <= opnd_b;
      latch_strobe_en <= !power_ctl_reg[`PW_STROBE_OFF];
      power_down_req  <= power_ctl_reg[`PW_DOWN];
      sleep_core_req  <= power_ctl_reg[`PW_SLEEP];
      baud_doubler    <= power_ctl_reg[7];
    end
  end

endmodule // core_memory_map

// file: tb/core_memory_map_chk.sv
// Concurrent checks on the core memory map ports.
`timescale 1ns/100ps
module core_memory_map_chk (
  input logic        clock,           // Core clock.
  input logic        reset_n,         // Async reset.
  input logic        ext_access_sel,  // Boot strap.
  input logic        dir_we,          // Direct write.
  input logic        dir_re,          // Direct read.
  input logic [7:0]  dir_addr,        // Direct address.
  input logic [7:0]  dir_wdata,       // Direct data.
  input logic        push_req,        // Push.
  input logic        pop_req,         // Pop.
  input logic        muldiv_we,       // Product write.
  input logic [15:0] muldiv_res,      // Product.
  input logic [7:0]  rd_data,         // Read data.
  input logic        rd_valid,        // Read valid.
  input logic        code_external,   // Code source.
  input logic [7:0]  bank_base,       // Bank base.
  input logic [7:0]  stack_ptr_out,   // Stack pointer.
  input logic [7:0]  math_out,        // Accumulator.
  input logic [7:0]  opnd_b_out,      // Operand b.
  input logic        latch_strobe_en  // Strobe allowed.
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [1:0] edges;
  logic       quiet;
  // Copy outputs lag a cycle, so stack steps are only judged after a calm cycle.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      edges <= 2'd0;
      quiet <= 1'b0;
    end else begin
      edges <= (edges == 2'd3) ? edges : edges + 2'd1;
      quiet <= !(push_req || pop_req || dir_we);
    end
  end
  strap_sample_a: assert property (edges == 2'd1 |-> code_external == !$past(ext_access_sel))
    else $error("code source does not follow the strap");
  strap_hold_a: assert property (edges == 2'd3 |-> $stable(code_external))
    else $error("code source moved after reset");
  read_answer_a: assert property (dir_re |=> rd_valid)
    else $error("direct read not answered");
  bank_select_a: assert property (dir_we && dir_addr == 8'hD0 |->
    ##2 bank_base == {3'b000, $past(dir_wdata[4:3], 2), 3'b000})
    else $error("bank base wrong");
  push_step_a: assert property (push_req && !pop_req && quiet |->
    ##2 stack_ptr_out == $past(stack_ptr_out, 2) + 8'd1)
    else $error("push did not raise the stack pointer");
  pop_step_a: assert property (pop_req && !push_req && quiet |->
    ##2 stack_ptr_out == $past(stack_ptr_out, 2) - 8'd1)
    else $error("pop did not lower the stack pointer");
  parity_bit_a: assert property (rd_valid && $past(dir_re && dir_addr == 8'hD0) |->
    rd_data[0] == ^math_out)
    else $error("parity bit wrong");
  product_store_a: assert property (muldiv_we |->
    ##2 {opnd_b_out, math_out} == $past(muldiv_res, 2))
    else $error("product not stored");
  strobe_off_a: assert property (dir_we && dir_addr == 8'h87 |->
    ##2 latch_strobe_en == !$past(dir_wdata[4], 2))
    else $error("latch strobe enable wrong");
endmodule // core_memory_map_chk
bind core_memory_map core_memory_map_chk chk (
  .clock(clock), .reset_n(reset_n), .ext_access_sel(ext_access_sel),
  .dir_we(dir_we), .dir_re(dir_re), .dir_addr(dir_addr), .dir_wdata(dir_wdata),
  .push_req(push_req), .pop_req(pop_req), .muldiv_we(muldiv_we), .muldiv_res(muldiv_res),
  .rd_data(rd_data), .rd_valid(rd_valid), .code_external(code_external),
  .bank_base(bank_base), .stack_ptr_out(stack_ptr_out), .math_out(math_out),
  .opnd_b_out(opnd_b_out), .latch_strobe_en(latch_strobe_en));

// file: tb/core_model.sv
// Processor core stand-in that issues one memory map request at a time.
`timescale 1ns/100ps
module core_model (
  input  logic        clock,    // Core clock.
  input  logic [7:0]  rd_data,  // Read answer.
  input  logic        rd_bit,   // Bit answer.
  output logic [12:0] stb,      // One-hot request strobes.
  output logic [7:0]  adr,      // Shared address.
  output logic [15:0] dat       // Shared write data.
);
  initial begin
    stb = 13'h0000;
    adr = 8'h00;
    dat = 16'h0000;
  end
  // Released lines are inverted so nothing can lean on a stale address or data.
  task automatic cyc(input int k, input logic [7:0] a, input logic [15:0] d,
                     output logic [7:0] q, output logic b);
    @(posedge clock);
    stb <= 13'h0001 << k;
    adr <= a;
    dat <= d;
    @(posedge clock);
    stb <= 13'h0000;
    adr <= ~a;
    dat <= ~d;
    #1;
    q = rd_data;
    b = rd_bit;
  endtask
endmodule // core_model

// file: tb/core_memory_map_tb.sv
// Self-checking bench for the core memory map block.
`timescale 1ns/100ps
module core_memory_map_tb;
  localparam int dw = 0, dr = 1, iw = 2, ir = 3, bw = 4, br = 5, rw = 6, rr = 7;
  localparam int pu = 8, po = 9, pi = 10, fl = 11, md = 12;
  logic        clock, reset_n, ext_access_sel, rd_bit, rd_valid, code_external, b;
  logic        dir_we, dir_re, ind_we, ind_re, bit_we, bit_re, reg_we, reg_re;
  logic        push_req, pop_req, ptr_inc, flags_we, muldiv_we, bit_wdata;
  logic        latch_strobe_en, power_down_req, sleep_core_req, baud_doubler;
  logic [2:0]  reg_sel;
  logic [3:0]  flags_in;
  logic [7:0]  dir_addr, dir_wdata, ind_addr, ind_wdata, bit_addr, reg_wdata, push_data;
  logic [7:0]  rd_data, bank_base, stack_ptr_out, math_out, opnd_b_out, adr, q;
  logic [12:0] stb;
  logic [15:0] muldiv_res, dat;
  logic [23:0] ext_data_addr;
  int          num_errors, check_count;
  assign {muldiv_we, flags_we, ptr_inc, pop_req, push_req, reg_re, reg_we,
          bit_re, bit_we, ind_re, ind_we, dir_re, dir_we} = stb;
  assign {dir_addr, ind_addr, bit_addr} = {3{adr}};
  assign {dir_wdata, ind_wdata, reg_wdata, push_data} = {4{dat[7:0]}};
  assign reg_sel = adr[2:0];
  assign bit_wdata = dat[0];
  assign flags_in = dat[3:0];
  assign muldiv_res = dat;
  core_model core (.clock(clock), .rd_data(rd_data), .rd_bit(rd_bit), .stb(stb),
                   .adr(adr), .dat(dat));
  core_memory_map dut (
    .clock(clock), .reset_n(reset_n), .ext_access_sel(ext_access_sel),
    .dir_we(dir_we), .dir_re(dir_re), .dir_addr(dir_addr), .dir_wdata(dir_wdata),
    .ind_we(ind_we), .ind_re(ind_re), .ind_addr(ind_addr), .ind_wdata(ind_wdata),
    .bit_we(bit_we), .bit_re(bit_re), .bit_addr(bit_addr), .bit_wdata(bit_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .push_req(push_req), .pop_req(pop_req), .push_data(push_data), .ptr_inc(ptr_inc),
    .flags_we(flags_we), .flags_in(flags_in), .muldiv_we(muldiv_we),
    .muldiv_res(muldiv_res), .rd_data(rd_data), .rd_bit(rd_bit), .rd_valid(rd_valid),
    .code_external(code_external), .ext_data_addr(ext_data_addr), .bank_base(bank_base),
    .stack_ptr_out(stack_ptr_out), .math_out(math_out), .opnd_b_out(opnd_b_out),
    .latch_strobe_en(latch_strobe_en), .power_down_req(power_down_req),
    .sleep_core_req(sleep_core_req), .baud_doubler(baud_doubler));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input int k, input logic [7:0] a, input logic [15:0] d);
    core.cyc(k, a, d, q, b);
  endtask
  task automatic rd(input int k, input logic [7:0] a, input logic [7:0] exp);
    core.cyc(k, a, 16'h0000, q, b);
    chk(q, exp);
  endtask
  task automatic do_reset(input logic strap);
    @(posedge clock);
    reset_n <= 1'b0;
    ext_access_sel <= strap;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    stop_test();
  end
  initial begin
    reset_n = 1'b0;
    ext_access_sel = 1'b1;
    num_errors = 0;
    check_count = 0;
    do_reset(1'b0);
    chk(code_external, 1'b1);
    do_reset(1'b1);
    chk(code_external, 1'b0);
    chk(latch_strobe_en, 1'b1);
    rd(dr, 8'h81, 8'h07);
    rd(dr, 8'hD0, 8'h00);
    rd(dr, 8'h87, 8'h00);
    for (int i = 0; i < 4; i++) begin
      op(dw, 8'hD0, 16'(i * 8));
      op(rw, 8'h05, 16'(8'hA0 + i));
      chk(bank_base, 8'(i * 8));
      rd(ir, 8'(i * 8 + 5), 8'(8'hA0 + i));
    end
    op(iw, 8'h21, 16'h0000);
    op(bw, 8'h0B, 16'h0001);
    rd(ir, 8'h21, 8'h08);
    op(br, 8'h0B, 16'h0000);
    chk(b, 1'b1);
    op(bw, 8'hD3, 16'h0000);
    rd(dr, 8'hD0, 8'h10);
    chk(bank_base, 8'h10);
    op(dw, 8'hF0, 16'h003C);
    op(iw, 8'hF0, 16'h00C3);
    rd(dr, 8'hF0, 8'h3C);
    rd(ir, 8'hF0, 8'hC3);
    op(dw, 8'h90, 16'h00FF);
    rd(dr, 8'h90, 8'h00);
    op(pu, 8'h00, 16'h005A);
    rd(dr, 8'h81, 8'h08);
    rd(ir, 8'h08, 8'h5A);
    rd(po, 8'h00, 8'h5A);
    rd(dr, 8'h81, 8'h07);
    op(dw, 8'h81, 16'h00FE);
    op(pu, 8'h00, 16'h0077);
    rd(ir, 8'hFF, 8'h77);
    op(dw, 8'h84, 16'h0012);
    op(dw, 8'h83, 16'h00FF);
    op(dw, 8'h82, 16'h00FF);
    op(pi, 8'h00, 16'h0000);
    rd(dr, 8'h84, 8'h13);
    rd(dr, 8'h82, 8'h00);
    chk(ext_data_addr, 24'h13_0000);
    op(dw, 8'h87, 16'h0093);
    rd(dr, 8'h87, 8'h93);
    chk({baud_doubler, latch_strobe_en, power_down_req, sleep_core_req}, 4'hB);
    op(dw, 8'h87, 16'h0000);
    op(md, 8'h00, 16'hA507);
    op(dw, 8'hD0, 16'h0000);
    chk({opnd_b_out, math_out}, 16'hA507);
    op(fl, 8'h00, 16'h000A);
    rd(dr, 8'hD0, 8'h85);
    rd(dr, 8'hE0, 8'h07);
    rd(rr, 8'h05, 8'hA0);
    stop_test();
  end
endmodule // core_memory_map_tb
